// ===== pwm_cmd_pkg.sv
// constants and types shared by the four-channel pwm block
package pwm_cmd_pkg;

	// ***************************************
	// sizes
	// ***************************************
	localparam int CH_NUM = 4; // channels wired to pins
	localparam int DUTY_W = 10; // duty width, 10-bit mode
	localparam int EN_W = 8; // enable byte width
	localparam int PRE_W = 7; // prescale counter width

	// ***************************************
	// register byte offsets
	// ***************************************
	localparam logic [5:0] OFS_DUTY1 = 6'h00; // duty 1..4 at +4 each
	localparam logic [5:0] OFS_FREQ = 6'h10;
	localparam logic [5:0] OFS_ENABLE = 6'h14;
	localparam logic [5:0] OFS_MODE = 6'h18;
	localparam logic [5:0] OFS_STATUS = 6'h1c;
	localparam int PERSIST_BIT = 5; // +0x20 alias also saves

	// ***************************************
	// mode characters and full scales
	// ***************************************
	localparam logic [7:0] CHAR_MODE8 = 8'h38; // '8'
	localparam logic [7:0] CHAR_MODE10 = 8'h61; // 'a'
	localparam logic [9:0] TOP_8 = 10'h0ff;
	localparam logic [9:0] TOP_10 = 10'h3ff;

	// ***************************************
	// timing
	// ***************************************
	localparam real CLK_KHZ = 200000.0; // 200 MHz system clock
	localparam real F_9K766_KHZ = 9.766; // 8-bit codes 0,1
	localparam real F_39K062_KHZ = 39.062; // 8-bit code 2
	localparam real F_156K25_KHZ = 156.25; // 8-bit code 3
	// clocks per pwm step; the 10-bit rates share the same three
	localparam logic [6:0] STEP_SLOW =
		7'($rtoi(CLK_KHZ / (F_9K766_KHZ * 256.0) + 0.5));
	localparam logic [6:0] STEP_MID =
		7'($rtoi(CLK_KHZ / (F_39K062_KHZ * 256.0) + 0.5));
	localparam logic [6:0] STEP_FAST =
		7'($rtoi(CLK_KHZ / (F_156K25_KHZ * 256.0) + 0.5));

	// ***************************************
	// reset values and types
	// ***************************************
	localparam logic [9:0] DUTY_RST = 10'h000;
	localparam logic [1:0] FREQ_RST = 2'h0;
	localparam logic [7:0] EN_RST = 8'h00;
	localparam logic MODE10_RST = 1'b0; // 8-bit after reset

	typedef struct packed {
		logic [7:0] enable; // bit n steers channel n+1
		logic [1:0] freq; // frequency code 0..3
		logic mode10; // 1 = 10-bit resolution
	} cfg_s;

endpackage : pwm_cmd_pkg

// ===== pwm_cmd.sv
// four-channel pwm generator with apb setup and saved settings
//
// Operation
// RULE1: duty write loads only the addressed channel
// RULE2: host keeps duty within current full scale
// RULE3: zero is always low, maximum always high
// RULE4: high fraction equals duty over 256/1024
// RULE5: persistent writes also saved, restored at reset
// RULE6: frequency code 0..3, read per mode
// RULE7: 8-bit rates 9.766, 9.766, 39.062, 156.25 kHz
// RULE8: 10-bit rates 2.441, 9.766, 39.062, 39.062 kHz
// RULE9: enable byte, bit 0 is channel 1
// RULE10: set bit enables, clear bit disables channel
// RULE11: only four low bits drive the pins
// RULE12: mode char '8' is 8-bit, 'a' 10-bit
// RULE13: disabled is low; new duty waits period end
// RULE14: mode or frequency change restarts at boundary

`timescale 1ns/1ps
`default_nettype none

module pwm_cmd #(
	parameter int CHANNELS = pwm_cmd_pkg::CH_NUM
) (
	input wire logic clk_sys_i, // system clock, 200 MHz
	input wire logic resetn_i, // board reset, async low
	input wire logic por_n_i, // power-on reset of saved image
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	output logic [CHANNELS-1:0] pwm_o // pins C1, C2, D0, D3
);

	// ***************************************
	// elaboration check
	// ***************************************
	// the map holds four duty words and the enable byte eight bits
	if (CHANNELS < 1 || CHANNELS > pwm_cmd_pkg::CH_NUM) begin : g_chk
		$error("pwm_cmd: CHANNELS must be 1..4");
	end

	// ***************************************
	// declarations
	// ***************************************
	logic [9:0] duty [CHANNELS]; // live duty per channel
	logic [9:0] duty_nv [CHANNELS]; // saved duty image
	logic [9:0] duty_act [CHANNELS]; // duty in use this period
	pwm_cmd_pkg::cfg_s cfg; // live settings
	pwm_cmd_pkg::cfg_s cfg_nv; // saved settings image
	pwm_cmd_pkg::cfg_s cfg_act; // settings in use this period
	logic restore; // first cycle after reset release
	logic [6:0] pre_cnt; // clocks within one step
	logic [9:0] per_cnt; // step within one period
	logic [6:0] step_top; // clocks per step for cfg_act
	logic [9:0] per_top; // last step of a period
	logic step_end; // last clock of a step
	logic boundary; // last clock of a period
	logic fire; // apb access completes this edge
	logic wr; // completing write
	logic persist; // address in saved alias
	logic [5:0] ofs; // offset with alias bit cleared
	logic dec_ok; // address decodes
	logic is_duty; // duty word addressed
	logic [1:0] duty_sel; // which duty word
	logic mode_ok; // written mode char is known
	logic next_mode10; // mode from written char
	logic [31:0] rd_val; // read mux result

	// ***************************************
	// apb decode
	// ***************************************
	// pready rises one cycle into the access phase
	assign fire = psel_i & penable_i & pready_o;
	assign wr = fire & pwrite_i;
	assign persist = paddr_i[pwm_cmd_pkg::PERSIST_BIT];
	assign ofs = {1'b0, paddr_i[4:0]};
	assign is_duty = (ofs < pwm_cmd_pkg::OFS_FREQ);
	assign duty_sel = ofs[3:2];

	// decode, mode char check and read mux
	always_comb begin
		dec_ok = 1'b0;
		rd_val = 32'h0000_0000;
		mode_ok = 1'b0;
		next_mode10 = cfg.mode10;
		// mode letter, unknown chars leave the mode alone
		if (pwdata_i[7:0] == pwm_cmd_pkg::CHAR_MODE8) begin
			mode_ok = 1'b1; // see RULE12
			next_mode10 = 1'b0;
		end else if (pwdata_i[7:0] == pwm_cmd_pkg::CHAR_MODE10) begin
			mode_ok = 1'b1; // see RULE12
			next_mode10 = 1'b1;
		end
		if (paddr_i[31:6] == 26'h0 && paddr_i[1:0] == 2'h0) begin
			if (is_duty) begin
				// only as many duty words as channels
				if (32'(duty_sel) < 32'(CHANNELS)) begin
					dec_ok = 1'b1;
					rd_val = persist ? 32'(duty_nv[duty_sel]) :
						32'(duty[duty_sel]);
				end
			end else begin
				case (ofs)
					pwm_cmd_pkg::OFS_FREQ: begin
						dec_ok = 1'b1;
						rd_val = persist ? 32'(cfg_nv.freq) :
							32'(cfg.freq);
					end
					pwm_cmd_pkg::OFS_ENABLE: begin
						dec_ok = 1'b1;
						rd_val = persist ? 32'(cfg_nv.enable) :
							32'(cfg.enable);
					end
					pwm_cmd_pkg::OFS_MODE: begin
						// reads back the mode letter
						dec_ok = 1'b1;
						rd_val = (persist ? cfg_nv.mode10 :
							cfg.mode10) ?
							32'(pwm_cmd_pkg::CHAR_MODE10) :
							32'(pwm_cmd_pkg::CHAR_MODE8);
					end
					pwm_cmd_pkg::OFS_STATUS: begin
						// read only, no saved alias
						dec_ok = !persist;
						rd_val = {16'h0000,
							2'h0, cfg != cfg_act,
							cfg_act.mode10, cfg_act.freq,
							per_cnt};
					end
					default: begin
						dec_ok = 1'b0;
					end
				endcase
			end
		end
	end

	// ***************************************
	// apb answer
	// ***************************************
	// one wait state, then a one-cycle pready
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i & penable_i & ~pready_o;
			if (psel_i & penable_i & ~pready_o) begin
				// error on unmapped, on status writes,
				// and on unknown mode letters
				prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
				pslverr_o <= ~dec_ok | (pwrite_i &
					(ofs == pwm_cmd_pkg::OFS_STATUS |
					(ofs == pwm_cmd_pkg::OFS_MODE & ~mode_ok)));
			end else begin
				prdata_o <= 32'h0000_0000;
				pslverr_o <= 1'b0;
			end
		end
	end

	// ***************************************
	// restore after reset
	// ***************************************
	// live settings load the saved image one clock after release
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			restore <= 1'b1;
		end else begin
			restore <= 1'b0;
		end
	end

	// ***************************************
	// live and saved settings
	// ***************************************
	// saved image survives board reset, cleared only at power-on
	always_ff @(posedge clk_sys_i or negedge por_n_i) begin
		if (!por_n_i) begin
			cfg_nv.enable <= pwm_cmd_pkg::EN_RST;
			cfg_nv.freq <= pwm_cmd_pkg::FREQ_RST;
			cfg_nv.mode10 <= pwm_cmd_pkg::MODE10_RST;
		end else if (wr & persist & dec_ok) begin
			// persistent writes land in the image too
			if (ofs == pwm_cmd_pkg::OFS_FREQ) begin
				cfg_nv.freq <= pwdata_i[1:0]; // see RULE5
			end
			if (ofs == pwm_cmd_pkg::OFS_ENABLE) begin
				cfg_nv.enable <= pwdata_i[7:0]; // see RULE5
			end
			if (ofs == pwm_cmd_pkg::OFS_MODE && mode_ok) begin
				cfg_nv.mode10 <= next_mode10; // see RULE5
			end
		end
	end

	// live settings steer the counters and outputs
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg.enable <= pwm_cmd_pkg::EN_RST;
			cfg.freq <= pwm_cmd_pkg::FREQ_RST;
			cfg.mode10 <= pwm_cmd_pkg::MODE10_RST;
		end else if (restore) begin
			cfg <= cfg_nv; // see RULE5
		end else if (wr & dec_ok) begin
			if (ofs == pwm_cmd_pkg::OFS_FREQ) begin
				cfg.freq <= pwdata_i[1:0]; // see RULE6
			end
			if (ofs == pwm_cmd_pkg::OFS_ENABLE) begin
				// all eight bits kept, upper ones drive nothing
				cfg.enable <= pwdata_i[7:0]; // see RULE9
			end
			if (ofs == pwm_cmd_pkg::OFS_MODE && mode_ok) begin
				cfg.mode10 <= next_mode10; // see RULE12
			end
		end
	end

	// ***************************************
	// period timing
	// ***************************************
	// clocks per step from the active mode and code
	always_comb begin
		case (cfg_act.freq)
			2'h0: step_top = pwm_cmd_pkg::STEP_SLOW; // see RULE7
			2'h1: begin
				// 10-bit code 1 is 9.766 kHz: mid step
				step_top = cfg_act.mode10 ? pwm_cmd_pkg::STEP_MID :
					pwm_cmd_pkg::STEP_SLOW; // see RULE8
			end
			2'h2: begin
				step_top = cfg_act.mode10 ? pwm_cmd_pkg::STEP_FAST :
					pwm_cmd_pkg::STEP_MID; // see RULE8
			end
			default: step_top = pwm_cmd_pkg::STEP_FAST; // see RULE7
		endcase
		per_top = cfg_act.mode10 ? pwm_cmd_pkg::TOP_10 :
			pwm_cmd_pkg::TOP_8; // see RULE4
	end

	assign step_end = (pre_cnt == step_top - 7'h01);
	assign boundary = step_end & (per_cnt == per_top);

	// step and period counters; new settings only at a boundary
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pre_cnt <= 7'h00;
			per_cnt <= 10'h000;
			cfg_act.enable <= pwm_cmd_pkg::EN_RST;
			cfg_act.freq <= pwm_cmd_pkg::FREQ_RST;
			cfg_act.mode10 <= pwm_cmd_pkg::MODE10_RST;
		end else if (boundary) begin
			// both counters restart with the new rate
			pre_cnt <= 7'h00;
			per_cnt <= 10'h000;
			cfg_act <= cfg; // see RULE14
		end else if (step_end) begin
			pre_cnt <= 7'h00;
			per_cnt <= per_cnt + 10'h001;
		end else begin
			pre_cnt <= pre_cnt + 7'h01;
		end
	end

	// ***************************************
	// per-channel duty and output
	// ***************************************
	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch // see RULE11
		// live duty, written by its own word only
		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				duty[c] <= pwm_cmd_pkg::DUTY_RST;
			end else if (restore) begin
				duty[c] <= duty_nv[c]; // see RULE5
			end else if (wr & is_duty & dec_ok &
				(32'(duty_sel) == c)) begin
				duty[c] <= pwdata_i[9:0]; // see RULE1
			end
		end

		// saved duty image, power-on only reset
		always_ff @(posedge clk_sys_i or negedge por_n_i) begin
			if (!por_n_i) begin
				duty_nv[c] <= pwm_cmd_pkg::DUTY_RST;
			end else if (wr & persist & is_duty & dec_ok &
				(32'(duty_sel) == c)) begin
				duty_nv[c] <= pwdata_i[9:0]; // see RULE5
			end
		end

		// duty in use, swapped at a boundary to avoid runt pulses
		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				duty_act[c] <= pwm_cmd_pkg::DUTY_RST;
			end else if (boundary) begin
				duty_act[c] <= duty[c]; // see RULE13
			end
		end

		// pin level: low when disabled, full scale forces high
		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				pwm_o[c] <= 1'b0;
			end else begin
				pwm_o[c] <= cfg.enable[c] & // see RULE10
					((duty_act[c] >= per_top) | // see RULE3
					(per_cnt < duty_act[c])); // see RULE4
			end
		end
	end

	// enable bits above the channel count reach no pin; see RULE11

endmodule : pwm_cmd

`default_nettype wire

// ===== pwm_cmd_properties.sv
// assertions on the apb answer and pin behaviour of the pwm block
`timescale 1ns/1ps
`default_nettype none
module pwm_cmd_properties #(
	parameter int CHANNELS = 4
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic por_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	input wire logic [CHANNELS-1:0] pwm_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	logic acc; // a transfer completes at this edge
	assign acc = psel_i && penable_i && pready_o;
	ready_wait_a:
		assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("ready late");
	ready_pulse_a:
		assert property (pready_o |=> !pready_o)
		else $error("ready held");
	ready_idle_a:
		assert property (!(psel_i && penable_i) |-> !pready_o)
		else $error("ready without access");
	idle_quiet_a:
		assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
		else $error("response outside ready");
	mode_err_a:
		assert property (acc && pwrite_i && paddr_i[4:0] == 5'h18 &&
			!(pwdata_i[7:0] inside {8'h38, 8'h61}) |-> pslverr_o)
		else $error("bad mode char accepted");
	status_ro_a:
		assert property (acc && pwrite_i && paddr_i[4:0] == 5'h1c |-> pslverr_o)
		else $error("status write accepted");
	bad_addr_a:
		assert property (acc && (paddr_i[1:0] != 2'h0 ||
			paddr_i[31:6] != 26'h0) |-> pslverr_o)
		else $error("bad address accepted");
	disable_low_a:
		assert property (acc && pwrite_i && !pslverr_o &&
			paddr_i[4:0] == 5'h14 && pwdata_i[CHANNELS-1:0] == '0
			|-> ##2 pwm_o == '0)
		else $error("disabled channel active");
	cover property (acc && pslverr_o);
	cover property (acc && !pwrite_i);
	cover property (acc && pwrite_i && paddr_i[4:0] == 5'h14);
endmodule : pwm_cmd_properties
bind pwm_cmd pwm_cmd_properties #(.CHANNELS(CHANNELS)) chk (
	.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .por_n_i(por_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.prdata_o(prdata_o), .pslverr_o(pslverr_o), .pwm_o(pwm_o));
`default_nettype wire

// ===== pwm_host.sv
// apb host model that sends the setup writes and reads
`timescale 1ns/1ps
`default_nettype none
module pwm_host (
	input wire logic clk_i,
	input wire logic pready_i,
	input wire logic [31:0] prdata_i,
	input wire logic pslverr_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [31:0] paddr_o,
	output logic [31:0] pwdata_o
);
	logic [31:0] rdata; // data of the last transfer
	logic err; // error flag of the last transfer
	initial begin
		{psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
	end
	// one transfer; values are passed as the caller keeps them in range
	task automatic xfer(input logic w, input logic [31:0] a, d);
		{psel_o, pwrite_o, paddr_o, pwdata_o} <= {1'b1, w, a, d};
		@(posedge clk_i);
		penable_o <= 1'b1;
		@(posedge clk_i);
		// wait for the answer; only the bench watchdog ends a dead wait
		while (pready_i !== 1'b1) begin
			@(posedge clk_i);
		end
		rdata = prdata_i;
		err = pslverr_i;
		{psel_o, penable_o} <= 2'b00;
		@(posedge clk_i);
	endtask : xfer
endmodule : pwm_host
`default_nettype wire

// ===== tb.sv
// self-checking bench for the four-channel pwm block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0, resetn = 1'b0, por_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0] pwm;
	int miscompares = 0, check_count = 0;
	logic [31:0] hi [4]; // high clocks per channel in one window
	always #2.5 clk = ~clk;
	pwm_cmd dut (.clk_sys_i(clk), .resetn_i(resetn), .por_n_i(por_n),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
		.prdata_o(prdata), .pslverr_o(pslverr), .pwm_o(pwm));
	pwm_host host (.clk_i(clk), .pready_i(pready), .prdata_i(prdata),
		.pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
		.pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
	task automatic check(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [31:0] a, d);
		host.xfer(1'b1, a, d);
	endtask : wr
	// wait until new settings are active, then 5120 more clocks
	task automatic settle;
		for (int n = 0; n < 400; n++) begin
			host.xfer(1'b0, 32'h1c, 32'h0);
			if (host.rdata[13] === 1'b0) break;
			repeat (64) @(posedge clk);
		end
		repeat (5120) @(posedge clk);
	endtask : settle
	task automatic measure(input int cyc);
		hi = '{default: 32'h0};
		repeat (cyc) begin
			@(posedge clk);
			for (int i = 0; i < 4; i++) hi[i] += 32'(pwm[i]);
		end
	endtask : measure
	task automatic t_duty8;
		wr(32'h10, 32'h3);
		wr(32'h00, 32'd128);
		wr(32'h08, 32'd255);
		wr(32'h0c, 32'd1);
		wr(32'h14, 32'hf7);
		settle;
		measure(1280);
		check(hi[0], 32'd640);
		check(hi[1], 32'd0);
		check(hi[2], 32'd1280);
		check(hi[3], 32'd0);
		$display("done duty8");
	endtask : t_duty8
	task automatic t_mode10;
		wr(32'h18, 32'h61);
		wr(32'h00, 32'd256);
		settle;
		measure(5120);
		check(hi[0], 32'd1280);
		check(hi[2], 32'd1275);
		host.xfer(1'b0, 32'h18, 32'h0);
		check(host.rdata, 32'h61);
		$display("done mode10");
	endtask : t_mode10
	task automatic t_freq8;
		wr(32'h18, 32'h38);
		wr(32'h10, 32'h2);
		wr(32'h00, 32'd64);
		settle;
		measure(5120);
		check(hi[0], 32'd1280);
		check(hi[2], 32'd5120);
		$display("done freq8");
	endtask : t_freq8
	task automatic t_errors;
		wr(32'h18, 32'h41);
		check(32'(host.err), 32'h1);
		host.xfer(1'b0, 32'h18, 32'h0);
		check(host.rdata, 32'h38);
		wr(32'h1c, 32'h0);
		check(32'(host.err), 32'h1);
		host.xfer(1'b0, 32'h40, 32'h0);
		check({host.rdata[30:0], host.err}, 32'h1);
		wr(32'h14, 32'h00);
		measure(1280);
		check(hi[0] | hi[2], 32'd0);
		$display("done errors");
	endtask : t_errors
	task automatic t_persist;
		wr(32'h34, 32'h05);
		wr(32'h20, 32'h020);
		resetn <= 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		host.xfer(1'b0, 32'h14, 32'h0);
		check(host.rdata, 32'h05);
		host.xfer(1'b0, 32'h00, 32'h0);
		check(host.rdata, 32'h020);
		host.xfer(1'b0, 32'h10, 32'h0);
		check(host.rdata, 32'h0);
		$display("done persist");
	endtask : t_persist
	task automatic give_verdict;
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (6) @(posedge clk);
		{por_n, resetn} <= 2'b11;
		repeat (2) @(posedge clk);
		t_duty8;
		t_mode10;
		t_freq8;
		t_errors;
		t_persist;
		give_verdict;
	end
	// watchdog: the tests need roughly 55000 clocks
	initial begin
		repeat (99000) @(posedge clk);
		miscompares++;
		give_verdict;
	end
endmodule : tb
`default_nettype wire
